// file: rtl/tcm_channel0.sv
// Timer channel 0 with mode, clock and trigger configuration
`timescale 1ns/1ps
module tcm_channel0
   import tcm_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input  wire logic             MCLK,
   input  wire logic             RST_B,
   // Register port
   input  wire logic [3:0]       ADDR,
   input  wire logic [15:0]      WDATA,
   input  wire logic             WR,
   input  wire logic             RD,
   output logic      [15:0]      RDATA,
   // Prescaler outputs and master channel (same clock)
   input  wire logic             PRESCALER_OUTPUT_A,
   input  wire logic             PRESCALER_OUTPUT_B,
   input  wire logic             MASTER_CHANNEL_IRQ,
   // Pins
   input  wire logic             TIMER_INPUT_PIN_ZERO,
   input  wire logic             TIMER_INPUT_PIN_THREE,
   output logic                  TIMER_OUT,
   // Events
   output logic                  CHANNEL_IRQ,
   output logic                  IRQ
);
   // Counter must fit the 16-bit register port
   if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
      $error("CNT_W must be 2..16");
   end

   // ==========================================================
   // Registers
   logic [7:0]        mode_high_q;
   logic [7:0]        mode_low_q;
   logic [CNT_W-1:0]  reload_q;
   logic [CNT_W-1:0]  count_q;
   logic [CNT_W-1:0]  capture_q;
   logic [NUM_EV-1:0] irq_stat_q;
   logic [NUM_EV-1:0] irq_mask_q;
   logic              enable_q;
   tcm_state_t        state_q;
   logic [2:0]        pin0_sync_q;
   logic [2:0]        pin3_sync_q;
   logic              pin0_q;
   logic              pin3_q;
   logic              pin3_prev_q;

   logic [2:0] trig_sel;
   logic [2:0] mode_sel;
   logic       start_irq_bit;
   logic [1:0] edge_sel;
   logic       wr_start;
   logic       wr_stop;
   assign trig_sel      = mode_high_q[2:0];
   assign mode_sel      = mode_low_q[3:1];
   assign start_irq_bit = mode_low_q[0];
   assign edge_sel      = mode_low_q[EDGE_SELECT_POS +: 2];
   assign wr_start      = WR && ADDR == ADDR_CONTROL && WDATA[CTRL_START_POS];
   assign wr_stop       = WR && ADDR == ADDR_CONTROL && WDATA[CTRL_STOP_POS];

   // ==========================================================
   // Pin synchronisers: change counts once stages 2 and 3 agree
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         pin0_sync_q <= 3'h0;
         pin3_sync_q <= 3'h0;
         pin0_q      <= 1'b0;
         pin3_q      <= 1'b0;
         pin3_prev_q <= 1'b0;
      end else begin
         pin0_sync_q <= {pin0_sync_q[1:0], TIMER_INPUT_PIN_ZERO};
         pin3_sync_q <= {pin3_sync_q[1:0], TIMER_INPUT_PIN_THREE};
         if (pin0_sync_q[2] == pin0_sync_q[1]) pin0_q <= pin0_sync_q[2];
         if (pin3_sync_q[2] == pin3_sync_q[1]) pin3_q <= pin3_sync_q[2];
         pin3_prev_q <= pin3_q;
      end
   end

   // Filtered pin 0 edges; edge select 00 falling, 01 rising, else both
   logic pin0_prev_q;
   always_ff @(posedge MCLK) begin
      if (!RST_B) pin0_prev_q <= 1'b0;
      else        pin0_prev_q <= pin0_q;
   end
   logic pin0_rise;
   logic pin0_fall;
   logic pin0_valid;
   logic pin0_both;
   logic pin3_valid;
   assign pin0_rise  = pin0_q && !pin0_prev_q;
   assign pin0_fall  = !pin0_q && pin0_prev_q;
   assign pin0_both  = pin0_rise || pin0_fall;
   assign pin0_valid = (edge_sel == 2'b00) ? pin0_fall :
                       (edge_sel == 2'b01) ? pin0_rise : pin0_both;
   assign pin3_valid = (edge_sel == 2'b01) ? (pin3_q && !pin3_prev_q) :
                       (!pin3_q && pin3_prev_q);

   // ==========================================================
   // Clock and trigger selection
   logic op_clock;
   logic count_tick;
   assign op_clock   = mode_high_q[OP_CLOCK_SELECT_POS] ? PRESCALER_OUTPUT_B
                                                        : PRESCALER_OUTPUT_A;
   assign count_tick = mode_high_q[COUNT_CLOCK_SOURCE_POS] ? pin0_valid
                                                           : op_clock;

   logic hw_trig;
   logic capture_trig;
   logic end_trig;
   always_comb begin
      hw_trig      = 1'b0;
      capture_trig = 1'b0;
      end_trig     = 1'b0;
      case (trig_sel)
         TRG_SOFTWARE: hw_trig = 1'b0;
         TRG_PIN_EDGE: begin
            hw_trig      = pin0_valid;
            capture_trig = pin0_valid;
         end
         TRG_PIN_BOTH: begin
            hw_trig      = pin0_both;
            capture_trig = pin0_both;
         end
         TRG_MASTER:    hw_trig = MASTER_CHANNEL_IRQ;
         TRG_MASTER_T3: begin
            hw_trig  = MASTER_CHANNEL_IRQ;
            end_trig = pin3_valid;
         end
         default: hw_trig = 1'b0;
      endcase
   end

   // Prohibited codes park the channel rather than guess a behaviour
   logic cfg_ok;
   assign cfg_ok = (trig_sel inside {TRG_SOFTWARE, TRG_PIN_EDGE, TRG_PIN_BOTH,
                                     TRG_MASTER, TRG_MASTER_T3})
                && ((mode_sel inside {MODE_INTERVAL, MODE_CAPTURE, MODE_ONECOUNT})
                    || (mode_sel inside {MODE_EVENT, MODE_CAP_ONE} && !start_irq_bit));

   logic count_up;
   logic one_count;
   logic start_trig;
   logic start_take;
   logic start_loud;
   assign count_up   = mode_sel == MODE_CAPTURE || mode_sel == MODE_CAP_ONE;
   assign one_count  = mode_sel == MODE_ONECOUNT || mode_sel == MODE_CAP_ONE;
   assign start_trig = cfg_ok && (wr_start || hw_trig);
   // Restart during a one-count run needs bit 0 set
   assign start_take = start_trig && !(state_q == ST_RUN && one_count
                                       && !start_irq_bit);
   assign start_loud = start_take && start_irq_bit
                    && mode_sel != MODE_EVENT && mode_sel != MODE_CAP_ONE;

   // ==========================================================
   // Counter engine
   logic expire;
   assign expire = state_q == ST_RUN && count_tick && !count_up
                && count_q == '0;

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         state_q  <= ST_IDLE;
         enable_q <= 1'b0;
         count_q  <= '0;
      end else if (wr_stop || !cfg_ok) begin
         state_q  <= ST_IDLE;
         enable_q <= 1'b0;
      end else if (start_take) begin
         state_q  <= ST_RUN;
         enable_q <= 1'b1;
         count_q  <= count_up ? '0 : reload_q;
      end else if (state_q == ST_RUN) begin
         case (mode_sel)
            MODE_INTERVAL, MODE_EVENT: begin
               if (count_tick) count_q <= expire ? reload_q : count_q - 1'b1;
            end
            MODE_ONECOUNT: begin
               if (expire) state_q <= ST_IDLE;
               else if (count_tick) count_q <= count_q - 1'b1;
            end
            MODE_CAPTURE: begin
               if (capture_trig) count_q <= '0;
               else if (count_tick) count_q <= count_q + 1'b1;
            end
            MODE_CAP_ONE: begin
               if (capture_trig || end_trig) state_q <= ST_IDLE;
               else if (count_tick) count_q <= count_q + 1'b1;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   logic capture_ev;
   assign capture_ev = state_q == ST_RUN && (capture_trig || end_trig)
                    && (mode_sel == MODE_CAPTURE || mode_sel == MODE_CAP_ONE);
   always_ff @(posedge MCLK) begin
      if (!RST_B)          capture_q <= '0;
      else if (capture_ev) capture_q <= count_q;
   end

   // Output toggles on expiry and on a loud start only
   always_ff @(posedge MCLK) begin
      if (!RST_B)                      TIMER_OUT <= 1'b0;
      else if (start_loud || expire)   TIMER_OUT <= !TIMER_OUT;
   end
   always_ff @(posedge MCLK) begin
      if (!RST_B) CHANNEL_IRQ <= 1'b0;
      else        CHANNEL_IRQ <= start_loud || expire || capture_ev;
   end

   // ==========================================================
   // Configuration registers; unused bits held at zero
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         mode_high_q <= MODE_HIGH_RESET;
         mode_low_q  <= MODE_LOW_RESET;
         reload_q    <= CNT_W'(RELOAD_RESET);
         irq_mask_q  <= '0;
      end else if (WR) begin
         case (ADDR)
            ADDR_MODE_HIGH: mode_high_q <= WDATA[7:0] & MODE_HIGH_MASK;
            ADDR_MODE_LOW:  mode_low_q  <= WDATA[7:0] & MODE_LOW_MASK;
            ADDR_RELOAD:    reload_q    <= WDATA[CNT_W-1:0];
            ADDR_IRQ_MASK:  irq_mask_q  <= WDATA[NUM_EV-1:0];
            default: ;
         endcase
      end
   end

   // Sticky events; a new event beats the read that clears
   logic [NUM_EV-1:0] ev_now;
   assign ev_now = {!cfg_ok && start_trig, end_trig && state_q == ST_RUN,
                    capture_ev, expire, start_take};
   always_ff @(posedge MCLK) begin
      if (!RST_B)                           irq_stat_q <= '0;
      else if (RD && ADDR == ADDR_IRQ_STATUS) irq_stat_q <= ev_now;
      else                                  irq_stat_q <= irq_stat_q | ev_now;
   end
   always_ff @(posedge MCLK) begin
      if (!RST_B) IRQ <= 1'b0;
      else        IRQ <= |((irq_stat_q | ev_now) & irq_mask_q
                           & ~((RD && ADDR == ADDR_IRQ_STATUS) ? irq_stat_q : '0));
   end

   // ==========================================================
   // Read port, data valid the cycle after the strobe
   always_ff @(posedge MCLK) begin
      if (!RST_B) RDATA <= 16'h0000;
      else if (RD) begin
         case (ADDR)
            ADDR_MODE_HIGH:  RDATA <= {8'h00, mode_high_q};
            ADDR_MODE_LOW:   RDATA <= {8'h00, mode_low_q};
            ADDR_STATUS:     RDATA <= {13'h0000, !cfg_ok, state_q == ST_RUN, enable_q};
            ADDR_IRQ_STATUS: RDATA <= 16'(irq_stat_q);
            ADDR_IRQ_MASK:   RDATA <= 16'(irq_mask_q);
            ADDR_COUNTER:    RDATA <= 16'(count_q);
            ADDR_RELOAD:     RDATA <= 16'(reload_q);
            ADDR_CAPTURE:    RDATA <= 16'(capture_q);
            default:         RDATA <= 16'h0000;
         endcase
      end else RDATA <= 16'h0000;
   end
endmodule : tcm_channel0

// file: rtl/tcm_pkg.sv
// Constants and types for the timer channel 0 mode configuration block
//
// Functional notes
// - Bit 7 high selects prescaler output B
// - Bit 4 high counts timer pin zero edges
// - Trigger 000: software start only
// - Trigger 001: selected pin edge starts, captures
// - Trigger 010: both pin edges start, capture
// - Trigger 100: master interrupt starts slave
// - Trigger 110: master starts, pin three ends a capture one-count run
// - Mode 000: interval timer, counts down
// - Mode 010: capture, counts up
// - Mode 0110: event counter, no start interrupt
// - Mode 100: one-count, counts down
// - Mode 1100: capture one-count, counts up
// - Interval/capture bit0 clear: quiet start
// - Interval/capture bit0 set: start interrupt, toggle
// - One-count bit0 clear: ignore restart triggers
// - One-count bit0 set: accept restart, interrupt
// - Capture one-count: quiet start, ignore restarts
// - Stop bit clears enable, halts counting
package tcm_pkg;
   // ==========================================================
   // Register map (word index on the plain port)
   localparam logic [3:0] ADDR_MODE_HIGH  = 4'h0;
   localparam logic [3:0] ADDR_MODE_LOW   = 4'h1;
   localparam logic [3:0] ADDR_CONTROL    = 4'h2;
   localparam logic [3:0] ADDR_STATUS     = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK   = 4'h5;
   localparam logic [3:0] ADDR_COUNTER    = 4'h6;
   localparam logic [3:0] ADDR_RELOAD     = 4'h7;
   localparam logic [3:0] ADDR_CAPTURE    = 4'h8;
   // ==========================================================
   // Field positions
   localparam int OP_CLOCK_SELECT_POS    = 7;
   localparam int COUNT_CLOCK_SOURCE_POS = 4;
   localparam int EDGE_SELECT_POS        = 6;
   localparam int CTRL_START_POS         = 0;
   localparam int CTRL_STOP_POS          = 1;
   localparam logic [7:0] MODE_HIGH_MASK = 8'h97;
   localparam logic [7:0] MODE_LOW_MASK  = 8'hcf;
   // ==========================================================
   // Reset values
   localparam logic [7:0]  MODE_HIGH_RESET = 8'h00;
   localparam logic [7:0]  MODE_LOW_RESET  = 8'h01;
   localparam logic [15:0] RELOAD_RESET    = 16'hffff;
   // Interrupt status bits
   localparam int EV_START   = 0;
   localparam int EV_EXPIRE  = 1;
   localparam int EV_CAPTURE = 2;
   localparam int EV_END     = 3;
   localparam int EV_BAD_CFG = 4;
   localparam int NUM_EV     = 5;
   // ==========================================================
   typedef enum logic [2:0] {
      TRG_SOFTWARE  = 3'b000,
      TRG_PIN_EDGE  = 3'b001,
      TRG_PIN_BOTH  = 3'b010,
      TRG_MASTER    = 3'b100,
      TRG_MASTER_T3 = 3'b110
   } tcm_trig_t;
   typedef enum logic [2:0] {
      MODE_INTERVAL = 3'b000,
      MODE_CAPTURE  = 3'b010,
      MODE_EVENT    = 3'b011,
      MODE_ONECOUNT = 3'b100,
      MODE_CAP_ONE  = 3'b110
   } tcm_mode_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } tcm_state_t;
endpackage : tcm_pkg

// file: verification/tcm_channel0_props.sv
// Checker for the timer channel 0 mode block
`timescale 1ns/1ps
module tcm_channel0_props
   import tcm_pkg::*;
(
   // Clock and reset
   input wire logic        MCLK,
   input wire logic        RST_B,
   // Register port
   input wire logic [3:0]  ADDR,
   input wire logic [15:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [15:0] RDATA,
   // Channel outputs
   input wire logic        TIMER_OUT,
   input wire logic        CHANNEL_IRQ
);
   // ==========================================
   // Shadow of the mode registers
   logic [7:0] hi_q;
   logic [7:0] lo_q;
   always_ff @(posedge MCLK) begin
      if (!RST_B) hi_q <= MODE_HIGH_RESET;
      else if (WR && ADDR == ADDR_MODE_HIGH) hi_q <= WDATA[7:0] & MODE_HIGH_MASK;
   end
   always_ff @(posedge MCLK) begin
      if (!RST_B) lo_q <= MODE_LOW_RESET;
      else if (WR && ADDR == ADDR_MODE_LOW) lo_q <= WDATA[7:0] & MODE_LOW_MASK;
   end
   logic ctl, stp, sta, loud, quiet, sw;
   assign ctl   = WR && ADDR == ADDR_CONTROL;
   assign stp   = ctl && WDATA[1:0] == 2'b10;
   assign sta   = ctl && WDATA[1:0] == 2'b01;
   assign sw    = hi_q[2:0] == 3'h0;
   assign loud  = sw && lo_q[3:0] inside {4'h1, 4'h5};
   assign quiet = sw && lo_q[3:0] inside {4'h0, 4'h4, 4'h6, 4'hc};
   // ==========================================
   // Properties
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   a_high_readback: assert property (WR && ADDR == ADDR_MODE_HIGH ##1 RD &&
      ADDR == ADDR_MODE_HIGH |=> RDATA == ($past(WDATA, 2) & {8'h00, MODE_HIGH_MASK}))
      else $error("mode high readback wrong");
   a_low_readback: assert property (WR && ADDR == ADDR_MODE_LOW ##1 RD &&
      ADDR == ADDR_MODE_LOW |=> RDATA == ($past(WDATA, 2) & {8'h00, MODE_LOW_MASK}))
      else $error("mode low readback wrong");
   a_stop_clears: assert property (stp ##1 RD && ADDR == ADDR_STATUS
      |=> RDATA[1:0] == 2'b00) else $error("stop left channel enabled");
   a_loud_irq: assert property (stp ##1 (sta && loud) |-> ##[1:3] CHANNEL_IRQ)
      else $error("no interrupt at loud start");
   a_loud_toggle: assert property (stp ##1 (sta && loud)
      |-> ##[1:3] $changed(TIMER_OUT)) else $error("output kept at loud start");
   a_quiet_start: assert property (stp ##1 (sta && quiet)
      |=> (!CHANNEL_IRQ && $stable(TIMER_OUT)) [*3]) else $error("quiet start was loud");
   a_oc_ignore: assert property (sta && sw && lo_q[3:0] == 4'h8 ##1 (!ctl) [*5]
      ##1 sta |=> (!CHANNEL_IRQ) [*3]) else $error("restart not ignored");
   a_oc_restart: assert property (sta && sw && lo_q[3:0] == 4'h9 ##1 (!ctl) [*5]
      ##1 sta |-> ##[1:3] CHANNEL_IRQ) else $error("restart gave no interrupt");
   c_loud: cover property (stp ##1 (sta && loud));
   c_quiet: cover property (stp ##1 (sta && quiet));
   c_restart: cover property (sta && sw && lo_q[3:0] == 4'h9);
endmodule : tcm_channel0_props
bind tcm_channel0 tcm_channel0_props tcm_channel0_props_i (.MCLK, .RST_B, .ADDR, .WDATA,
   .WR, .RD, .RDATA, .TIMER_OUT, .CHANNEL_IRQ);

// file: verification/tcm_far_model.sv
// Far-side model: prescaler ticks, master channel pulse, timer pin
`timescale 1ns/1ps
module tcm_far_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Requests from the bench
   input  wire logic master_req,
   input  wire logic pin0_lvl,
   // Block side
   output logic      presc_a,
   output logic      presc_b,
   output logic      master_irq,
   output logic      pin0
);
   logic [1:0] div_q;
   always_ff @(posedge clk) begin
      if (!rst_b) div_q <= 2'h0;
      else div_q <= div_q + 2'h1;
   end
   // B ticks one cycle in four, so a clock mix-up shows in the count
   always_ff @(posedge clk) begin
      presc_a <= rst_b;
      presc_b <= rst_b && div_q == 2'h3;
      master_irq <= rst_b && master_req;
   end
   // The pin is asynchronous: keep it off the clock edge
   assign #2 pin0 = pin0_lvl;
endmodule : tcm_far_model

// file: verification/tcm_channel0_bench.sv
// Self-checking bench for the timer channel 0 mode block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected at %0t: got %h, want %h", $time, g, e); end end
module tcm_channel0_bench
   import tcm_pkg::*;
;
   logic        MCLK = 1'b0;
   logic        RST_B = 1'b0;
   logic [3:0]  ADDR = 4'h0;
   logic [15:0] WDATA = 16'h0000;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   logic [15:0] RDATA, got, want, rl;
   logic        TIMER_OUT, CHANNEL_IRQ, IRQ, pa, pb, mirq, p0;
   logic        mreq = 1'b0, lvl0 = 1'b0, lvl3 = 1'b0, rd_q = 1'b0;
   logic [15:0] exp_q[$], msk_q[$];
   int          error_cnt = 0, compares = 0, cyc = 0;
   integer      seed = 32'h40bb3b75;
   logic [3:0]  modes[8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc};
   // Entry: expect running, pin edge (else master), trigger code
   logic [4:0]  trg[7] = '{5'h00, 5'h08, 5'h14, 5'h09, 5'h1a, 5'h16, 5'h0c};
   always #4 MCLK = ~MCLK;
   tcm_far_model tcm_far_model_i (.clk(MCLK), .rst_b(RST_B), .master_req(mreq),
      .pin0_lvl(lvl0), .presc_a(pa), .presc_b(pb), .master_irq(mirq), .pin0(p0));
   tcm_channel0 tcm_channel0_i (.MCLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA,
      .PRESCALER_OUTPUT_A(pa), .PRESCALER_OUTPUT_B(pb), .MASTER_CHANNEL_IRQ(mirq),
      .TIMER_INPUT_PIN_ZERO(p0), .TIMER_INPUT_PIN_THREE(lvl3), .TIMER_OUT, .CHANNEL_IRQ,
      .IRQ);
   // ==========================================
   // Bus tasks: entered just after an edge, wr and rd leave the strobe up, idle drops it
   task automatic idle(input int n);
      WR <= 1'b0;
      RD <= 1'b0;
      repeat (n) @(posedge MCLK);
   endtask : idle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      WR <= 1'b1;
      RD <= 1'b0;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      WR <= 1'b0;
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
   endtask : rd
   task automatic end_sim;
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   always @(posedge MCLK) begin
      if (rd_q) begin
         want = exp_q.pop_front();
         got = RDATA & msk_q.pop_front();
         `CHK(got, want)
      end
      rd_q <= RD;
   end
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_sim();
      end
   end
   // ==========================================
   initial begin
      repeat (8) @(posedge MCLK);
      RST_B <= 1'b1;
      rl = 16'h0010 + (16'($random(seed)) & 16'h000f);
      @(posedge MCLK);
      rd(ADDR_MODE_HIGH, {8'h00, MODE_HIGH_RESET}, 16'hffff);
      rd(ADDR_MODE_LOW, {8'h00, MODE_LOW_RESET}, 16'hffff);
      rd(ADDR_RELOAD, RELOAD_RESET, 16'hffff);
      rd(4'hf, 16'h0000, 16'hffff);
      wr(ADDR_MODE_HIGH, 16'h00ff);
      rd(ADDR_MODE_HIGH, 16'h0097, 16'hffff);
      wr(ADDR_MODE_LOW, 16'h00ff);
      rd(ADDR_MODE_LOW, 16'h00cf, 16'hffff);
      rd(ADDR_STATUS, 16'h0004, 16'h0004);
      // Software start in each mode, then a start while counting
      foreach (modes[i]) begin
         wr(ADDR_CONTROL, 16'h0002);
         wr(ADDR_MODE_HIGH, 16'h0000);
         wr(ADDR_MODE_LOW, {12'h000, modes[i]});
         wr(ADDR_CONTROL, 16'h0002);
         wr(ADDR_CONTROL, 16'h0001);
         rd(ADDR_STATUS, 16'h0003, 16'h0007);
         idle(4);
         wr(ADDR_CONTROL, 16'h0001);
         idle(6);
      end
      wr(ADDR_CONTROL, 16'h0002);
      rd(ADDR_STATUS, 16'h0000, 16'h0003);
      // Slow clock B must not reach expiry in time; clock A must
      wr(ADDR_IRQ_MASK, 16'h001f);
      wr(ADDR_RELOAD, rl);
      wr(ADDR_MODE_HIGH, 16'h0080);
      wr(ADDR_MODE_LOW, 16'h0000);
      rd(ADDR_IRQ_STATUS, 16'h0000, 16'h0000);
      wr(ADDR_CONTROL, 16'h0001);
      idle(40);
      rd(ADDR_IRQ_STATUS, 16'h0000, 16'h0002);
      wr(ADDR_CONTROL, 16'h0002);
      wr(ADDR_MODE_HIGH, 16'h0000);
      wr(ADDR_CONTROL, 16'h0001);
      idle(40);
      wr(ADDR_CONTROL, 16'h0002);
      idle(2);
      `CHK(IRQ, 1'b1)
      wr(ADDR_IRQ_MASK, 16'h0000);
      idle(2);
      `CHK(IRQ, 1'b0)
      rd(ADDR_IRQ_STATUS, 16'h0002, 16'h0002);
      idle(3);
      `CHK(IRQ, 1'b0)
      // Count clock taken from rising edges of pin zero
      wr(ADDR_MODE_HIGH, 16'h0010);
      wr(ADDR_MODE_LOW, 16'h0040);
      wr(ADDR_RELOAD, 16'h0003);
      wr(ADDR_CONTROL, 16'h0001);
      idle(20);
      rd(ADDR_IRQ_STATUS, 16'h0000, 16'h0002);
      repeat (12) begin
         lvl0 <= ~lvl0;
         idle(8);
      end
      rd(ADDR_IRQ_STATUS, 16'h0002, 16'h0002);
      // Start trigger sources against each trigger code
      foreach (trg[i]) begin
         lvl0 <= 1'b0;
         idle(10);
         wr(ADDR_CONTROL, 16'h0002);
         wr(ADDR_MODE_HIGH, {13'h0, trg[i][2:0]});
         wr(ADDR_MODE_LOW, 16'h0000);
         if (trg[i][3]) lvl0 <= 1'b1;
         else mreq <= 1'b1;
         idle(1);
         mreq <= 1'b0;
         idle(10);
         rd(ADDR_STATUS, {14'h0, {2{trg[i][4]}}}, 16'h0003);
      end
      // Master start, then only a falling edge of pin three ends the run
      lvl0 <= 1'b0;
      idle(10);
      wr(ADDR_CONTROL, 16'h0002);
      wr(ADDR_MODE_HIGH, 16'h0006);
      wr(ADDR_MODE_LOW, 16'h000c);
      mreq <= 1'b1;
      idle(1);
      mreq <= 1'b0;
      idle(4);
      rd(ADDR_STATUS, 16'h0003, 16'h0003);
      lvl3 <= 1'b1;
      idle(10);
      rd(ADDR_STATUS, 16'h0002, 16'h0002);
      lvl3 <= 1'b0;
      idle(10);
      rd(ADDR_STATUS, 16'h0000, 16'h0002);
      idle(2);
      end_sim();
   end
endmodule : tcm_channel0_bench
